// *** zcf_pkg.sv ***
// Package with register map, field positions and timing constants.
package zcf_pkg;
  localparam int          REF_CLK_HZ     = 4_000_000;
  localparam int          BLANK_LO_NS    = 5_000;
  localparam int          BLANK_HI_NS    = 20_000;
  localparam int          SAMPLE_BASE_NS = 1_000;
  localparam int          BLANK_LO_CYC   = BLANK_LO_NS * (REF_CLK_HZ / 1_000_000) / 1_000;
  localparam int          BLANK_HI_CYC   = BLANK_HI_NS * (REF_CLK_HZ / 1_000_000) / 1_000;
  localparam int          SAMPLE_CYC     = SAMPLE_BASE_NS * (REF_CLK_HZ / 1_000_000) / 1_000;
  localparam int          BLANK_HI_FIRST = 8;
  localparam int          BLANK_HI_BIAS  = 5;
  localparam logic [4:0]  ADDR_ZFR       = 5'h00;
  localparam logic [4:0]  ADDR_SCR       = 5'h04;
  localparam logic [4:0]  ADDR_CTRL      = 5'h08;
  localparam logic [4:0]  ADDR_STAT      = 5'h0c;
  localparam logic [7:0]  ZFR_RESET      = 8'h0f;
  localparam logic [7:0]  SCR_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  SCR_WMASK      = 8'h8f;
  localparam logic [7:0]  CTRL_WMASK     = 8'h7f;
  localparam int          ZFR_CNT_LSB    = 4;
  localparam int          ZFR_WIN_LSB    = 0;
  localparam int          SCR_ZSV_BIT    = 7;
  localparam int          SCR_SCF_LSB    = 2;
  localparam int          SCR_ECM_BIT    = 1;
  localparam int          SCR_FLOAT_BIT  = 0;
  localparam int          CTRL_MOE_BIT   = 0;
  localparam int          CTRL_SR_BIT    = 1;
  localparam int          CTRL_PCN_BIT   = 2;
  localparam int          CTRL_TES_LSB   = 3;
  localparam int          CTRL_PWM_BIT   = 5;
  localparam int          CTRL_ENC_BIT   = 6;
  localparam int          STAT_SEEN_BIT  = 0;
  localparam int          STAT_BLANK_BIT = 1;
  localparam int          STAT_FLOAT_BIT = 2;
  localparam int          STAT_RUN_LSB   = 4;
  localparam int          BLANK_W        = 10;
  localparam int          DIV_W          = 6;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } zcf_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } zcf_av_rsp_t;

  typedef struct packed {
    logic d_event;
    logic pwm_sample;
    logic rtc_tick;
    logic timer_high_rd;
  } zcf_evt_in_t;
endpackage

// *** zcf_filter.sv ***
// Zero-crossing event filter, blanking window and sampling clock block.
//
// Operation
// - A Z event needs the count field value plus one consecutive samples.
// - Only consecutive valid detections count, sampled at the divided clock or at the PWM rate.
// - Each D event with sensor mode clear opens a blanking window during which Z detection is ignored.
// - Window codes 0-7 give 5-40 us in 5 us steps and 8-15 give 60-200 us in 20 us steps at 4 MHz.
// - The sampling valid bit enables Z sampling while the motor output enable is clear.
// - The sampling clock field divides the clock by 4, 8, 16 or 32 for 1 MHz down to 125 kHz.
// - In encoder sensing the capture source is the RTC tick or a read of the timer high byte.
// - The float bit grounds unused phase inputs when clear and floats them when set.
// - The float bit acts only with independent phase clear, tacho edge 00 and sensor mode clear.
// - After reset the sampling clock register reads 00h.
`timescale 1ns/1ps
`default_nettype none
module zcf_filter
  import zcf_pkg::*;
(
  input  wire logic                 clock,         // Peripheral clock.
  input  wire logic                 sys_rst,       // Synchronous reset.
  input  wire zcf_pkg::zcf_av_req_t av_req,        // Avalon-MM request.
  output var  zcf_pkg::zcf_av_rsp_t av_rsp,        // Avalon-MM response.
  input  wire zcf_pkg::zcf_evt_in_t evt_in,        // Same-domain strobes.
  input  wire logic                 zc_detect,     // Comparator pin level.
  output logic                      zc_event,      // Validated Z pulse.
  output logic                      blank_active,  // Window running.
  output logic                      phase_gnd_en,  // Ground unused phases.
  output logic                      capture_strobe // Timer capture pulse.
);
  import zcf_pkg::*;

  typedef struct packed {
    logic [7:0]         zfr;
    logic [7:0]         scr;
    logic [7:0]         ctrl;
    logic               seen;
    logic [1:0]         zc_sync;
    logic [BLANK_W-1:0] blank_cnt;
    logic [DIV_W-1:0]   div_cnt;
    logic               div_tick;
    logic [3:0]         run_cnt;
    logic               zc_event;
    logic               blank_active;
    logic               gnd_en;
    logic               capture;
    logic [31:0]        readdata;
    logic               waitrequest;
  } zcf_state_t;

  zcf_state_t s_r;
  zcf_state_t s_nxt;

  // Window length in clock cycles for a 4-bit code.
  function automatic logic [BLANK_W-1:0] win_cycles(input logic [3:0] code);
    int n;
    if (int'(code) < BLANK_HI_FIRST) begin
      n = (int'(code) + 1) * BLANK_LO_CYC;
    end else begin
      n = (int'(code) - BLANK_HI_BIAS) * BLANK_HI_CYC;
    end
    return BLANK_W'(n);
  endfunction

  logic [3:0]       cnt_sel;
  logic [3:0]       win_sel;
  logic [1:0]       scf_sel;
  logic [DIV_W-1:0] div_last;
  logic             sample_tick;
  logic             sample_en;
  logic             float_ok;
  logic             acc_wr;
  logic             acc_rd;
  logic [7:0]       wbyte;

  always_comb begin
    cnt_sel     = s_r.zfr[ZFR_CNT_LSB +: 4];
    win_sel     = s_r.zfr[ZFR_WIN_LSB +: 4];
    scf_sel     = s_r.scr[SCR_SCF_LSB +: 2];
    div_last    = DIV_W'((SAMPLE_CYC << scf_sel) - 1);
    sample_tick = s_r.ctrl[CTRL_PWM_BIT] ? evt_in.pwm_sample
                                         : s_r.div_tick;
    sample_en   = s_r.ctrl[CTRL_MOE_BIT] | s_r.scr[SCR_ZSV_BIT];
    float_ok    = !s_r.ctrl[CTRL_PCN_BIT] && !s_r.ctrl[CTRL_SR_BIT]
                  && (s_r.ctrl[CTRL_TES_LSB +: 2] == 2'b00);
    acc_wr      = av_req.write && !s_r.waitrequest && av_req.byteenable[0];
    acc_rd      = av_req.read && s_r.waitrequest;
    wbyte       = av_req.writedata[7:0];

    s_nxt = s_r;

    // Bus answers one cycle after the request is seen.
    s_nxt.waitrequest = !((av_req.read || av_req.write) && s_r.waitrequest);
    if (acc_rd) begin
      case (av_req.address)
        ADDR_ZFR:  s_nxt.readdata = {24'h000000, s_r.zfr};
        ADDR_SCR:  s_nxt.readdata = {24'h000000, s_r.scr};
        ADDR_CTRL: s_nxt.readdata = {24'h000000, s_r.ctrl};
        ADDR_STAT: s_nxt.readdata = {24'h000000, s_r.run_cnt, 1'b0,
                                     float_ok & s_r.scr[SCR_FLOAT_BIT],
                                     s_r.blank_active, s_r.seen};
        default:   s_nxt.readdata = 32'h00000000;
      endcase
    end
    if (acc_wr) begin
      case (av_req.address)
        ADDR_ZFR:  s_nxt.zfr  = wbyte;
        ADDR_SCR:  s_nxt.scr  = wbyte & SCR_WMASK;
        ADDR_CTRL: s_nxt.ctrl = wbyte & CTRL_WMASK;
        ADDR_STAT: begin
          if (wbyte[STAT_SEEN_BIT]) begin
            s_nxt.seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    s_nxt.zc_sync = {s_r.zc_sync[0], zc_detect};

    // Sampling clock divider, counted in clock cycles.
    if (s_r.div_cnt >= div_last) begin
      s_nxt.div_cnt  = '0;
      s_nxt.div_tick = 1'b1;
    end else begin
      s_nxt.div_cnt  = s_r.div_cnt + 1'b1;
      s_nxt.div_tick = 1'b0;
    end

    // Blanking window restarts on every D event with sensor mode clear.
    if (evt_in.d_event && !s_r.ctrl[CTRL_SR_BIT]) begin
      s_nxt.blank_cnt = win_cycles(win_sel);
    end else if (evt_in.d_event) begin
      s_nxt.blank_cnt = '0;
    end else if (s_r.blank_cnt != '0) begin
      s_nxt.blank_cnt = s_r.blank_cnt - 1'b1;
    end
    s_nxt.blank_active = (s_nxt.blank_cnt != '0);

    // Consecutive sample counter.
    s_nxt.zc_event = 1'b0;
    if (evt_in.d_event || !sample_en || s_r.blank_cnt != '0) begin
      s_nxt.run_cnt = '0;
    end else if (sample_tick) begin
      if (!s_r.zc_sync[1]) begin
        s_nxt.run_cnt = '0;
      end else if (s_r.run_cnt == cnt_sel) begin
        s_nxt.run_cnt  = '0;
        s_nxt.zc_event = 1'b1;
      end else begin
        s_nxt.run_cnt = s_r.run_cnt + 1'b1;
      end
    end
    if (s_nxt.zc_event) begin
      s_nxt.seen = 1'b1;
    end

    s_nxt.gnd_en  = !(float_ok && s_r.scr[SCR_FLOAT_BIT]);
    s_nxt.capture = s_r.ctrl[CTRL_ENC_BIT] &&
                    (s_r.scr[SCR_ECM_BIT] ? evt_in.timer_high_rd
                                          : evt_in.rtc_tick);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r             <= '0;
      s_r.zfr         <= ZFR_RESET;
      s_r.scr         <= SCR_RESET;
      s_r.ctrl        <= CTRL_RESET;
      s_r.gnd_en      <= 1'b1;
      s_r.waitrequest <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign av_rsp.readdata    = s_r.readdata;
  assign av_rsp.waitrequest = s_r.waitrequest;
  assign zc_event           = s_r.zc_event;
  assign blank_active       = s_r.blank_active;
  assign phase_gnd_en       = s_r.gnd_en;
  assign capture_strobe     = s_r.capture;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  evt_count_a: assert property (
    s_r.zc_event |-> $past(s_r.run_cnt) == $past(cnt_sel)
  ) else $error("Z event raised before the sample count was reached");

  consec_reset_a: assert property (
    sample_tick && !s_r.zc_sync[1] |=> s_r.run_cnt == 4'h0 && !s_r.zc_event
  ) else $error("Invalid sample did not restart the count");

  blank_gate_a: assert property (
    s_r.blank_cnt != '0 |=> !s_r.zc_event
  ) else $error("Z event raised inside the blanking window");

  blank_len_a: assert property (
    evt_in.d_event && !s_r.ctrl[CTRL_SR_BIT]
    |=> s_r.blank_cnt == win_cycles($past(win_sel)) && s_r.blank_active
  ) else $error("Blanking window loaded with the wrong length");

  sensor_noblank_a: assert property (
    evt_in.d_event && s_r.ctrl[CTRL_SR_BIT] |=> !s_r.blank_active
  ) else $error("Blanking window opened in sensor mode");

  zsv_gate_a: assert property (
    !s_r.ctrl[CTRL_MOE_BIT] && !s_r.scr[SCR_ZSV_BIT] |=> !s_r.zc_event
  ) else $error("Z event raised with sampling disabled");

  div_space_a: assert property (
    s_r.div_tick |=> !s_r.div_tick [*3]
  ) else $error("Sampling tick spacing below four cycles");

  reserved_zero_a: assert property (
    s_r.scr[6:4] == 3'b000
  ) else $error("Reserved sampling clock bits not zero");

  float_gate_a: assert property (
    !$past(float_ok) |-> s_r.gnd_en
  ) else $error("Unused inputs floated outside the allowed mode");

  capture_src_a: assert property (
    s_r.capture == $past(s_r.ctrl[CTRL_ENC_BIT] && (s_r.scr[SCR_ECM_BIT]
                   ? evt_in.timer_high_rd : evt_in.rtc_tick))
  ) else $error("Capture strobe from the wrong source");

  reset_val_a: assert property (
    $past(sys_rst) |-> s_r.scr == SCR_RESET && s_r.gnd_en
  ) else $error("Sampling clock register not cleared by reset");

  // Bus handshake and register checks.
  bus_answer_a: assert property (
    (av_req.read || av_req.write) && s_r.waitrequest |=> !s_r.waitrequest
  ) else $error("Bus request not answered after one cycle");

  bus_idle_a: assert property (
    !(av_req.read || av_req.write) && s_r.waitrequest |=> s_r.waitrequest
  ) else $error("Bus answered without a request");

  bus_one_a: assert property (
    !s_r.waitrequest |=> s_r.waitrequest
  ) else $error("Bus answer held longer than one cycle");

  rd_upper_a: assert property (
    s_r.readdata[31:8] == 24'h000000
  ) else $error("Upper read data bits not zero");

  ctrl_top_a: assert property (
    s_r.ctrl[7] == 1'b0
  ) else $error("Unused control bit not zero");

  wr_scr_a: assert property (
    acc_wr && av_req.address == ADDR_SCR
    |=> s_r.scr == $past(wbyte & SCR_WMASK)
  ) else $error("Sampling clock register write lost");

  wr_zfr_a: assert property (
    acc_wr && av_req.address == ADDR_ZFR |=> s_r.zfr == $past(wbyte)
  ) else $error("Filter register write lost");

  wr_ctrl_a: assert property (
    acc_wr && av_req.address == ADDR_CTRL
    |=> s_r.ctrl == $past(wbyte & CTRL_WMASK)
  ) else $error("Control register write lost");

  stat_seen_a: assert property (
    acc_rd && av_req.address == ADDR_STAT
    |=> s_r.readdata[0] == $past(s_r.seen)
  ) else $error("Status read does not show the seen flag");

  seen_set_a: assert property (
    s_r.zc_event |-> s_r.seen
  ) else $error("Seen flag not set by a Z event");

  seen_clear_a: assert property (
    acc_wr && av_req.address == ADDR_STAT && wbyte[STAT_SEEN_BIT]
    && !s_nxt.zc_event |=> !s_r.seen
  ) else $error("Seen flag not cleared by software");

  // Blanking and counting checks.
  blank_flag_a: assert property (
    s_r.blank_active == (s_r.blank_cnt != '0)
  ) else $error("Blanking flag disagrees with its counter");

  blank_step_a: assert property (
    s_r.blank_cnt != '0 && !evt_in.d_event
    |=> s_r.blank_cnt == $past(s_r.blank_cnt) - 1'b1
  ) else $error("Blanking counter did not count down");

  blank_cancel_a: assert property (
    evt_in.d_event && s_r.ctrl[CTRL_SR_BIT] |=> s_r.blank_cnt == '0
  ) else $error("Blanking counter kept running in sensor mode");

  blank_run_a: assert property (
    s_r.blank_cnt != '0 |=> s_r.run_cnt == 4'h0
  ) else $error("Samples counted inside the blanking window");

  dis_clear_a: assert property (
    !sample_en |=> s_r.run_cnt == 4'h0
  ) else $error("Samples counted with sampling disabled");

  run_hold_a: assert property (
    sample_en && !sample_tick && !evt_in.d_event && s_r.blank_cnt == '0
    |=> $stable(s_r.run_cnt)
  ) else $error("Sample count moved without a sample tick");

  run_step_a: assert property (
    sample_en && sample_tick && s_r.zc_sync[1] && !evt_in.d_event
    && s_r.blank_cnt == '0 && s_r.run_cnt != cnt_sel
    |=> s_r.run_cnt == $past(s_r.run_cnt) + 1'b1
  ) else $error("Valid sample did not advance the count");

  div_len_a: assert property (
    s_r.div_tick |-> $past(s_r.div_cnt) >= $past(div_last)
  ) else $error("Sampling tick raised before the divider end");

  sync_pipe_a: assert property (
    s_r.zc_sync[1] == $past(s_r.zc_sync[0])
  ) else $error("Comparator synchroniser skipped a stage");

  // Output stage checks.
  gnd_float_a: assert property (
    float_ok && s_r.scr[SCR_FLOAT_BIT] |=> !s_r.gnd_en
  ) else $error("Unused inputs not floated when selected");

  gnd_hold_a: assert property (
    !s_r.scr[SCR_FLOAT_BIT] |=> s_r.gnd_en
  ) else $error("Unused inputs floated with the float bit clear");

  cap_off_a: assert property (
    !s_r.ctrl[CTRL_ENC_BIT] |=> !s_r.capture
  ) else $error("Capture strobe outside encoder sensing");

  zc_seen_c: cover property (s_r.zc_event && cnt_sel != 4'h0);
  sensor_c: cover property (evt_in.d_event && s_r.ctrl[CTRL_SR_BIT]);
  blank_end_c: cover property ($fell(s_r.blank_active));
  pwm_rate_c: cover property (s_r.ctrl[CTRL_PWM_BIT] && s_r.zc_event);
  float_c: cover property (!s_r.gnd_en);
endmodule
`default_nettype wire

// *** zcf_cmp_model.sv ***
// Behavioural model of the back-EMF comparator seen on a phase input.
`timescale 1ns/1ps
`default_nettype none
module zcf_cmp_model (
  input  wire logic clock,     // Peripheral clock.
  input  wire logic level,     // Commanded comparator level.
  output logic      zc_detect  // Comparator output pin.
);
  // The comparator output changes just after an edge, like a real pin.
  always_ff @(posedge clock) begin
    zc_detect <= level;
  end
endmodule
`default_nettype wire

// *** zcf_filter_tb.sv ***
// Self-checking testbench for the zero-crossing filter block.
`timescale 1ns/1ps
`default_nettype none
module zcf_filter_tb;
  import zcf_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  zcf_av_req_t av_req = '0;
  zcf_av_rsp_t av_rsp;
  zcf_evt_in_t evt_in = '0;
  logic        zc_level = 1'b0;
  logic        zc_detect, zc_event, blank_active, phase_gnd_en, cap;
  int          err_count = 0;
  int          compares = 0;
  int          n;
  logic [7:0]  rd;
  logic [7:0]  ctl [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
  always #50 clock = ~clock;
  zcf_filter uut (.clock(clock), .sys_rst(sys_rst), .av_req(av_req),
    .av_rsp(av_rsp), .evt_in(evt_in), .zc_detect(zc_detect),
    .zc_event(zc_event), .blank_active(blank_active),
    .phase_gnd_en(phase_gnd_en), .capture_strobe(cap));
  zcf_cmp_model cmp (.clock(clock), .level(zc_level), .zc_detect(zc_detect));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    av_req.read <= ~wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.byteenable <= 4'hf;
    av_req.writedata <= {24'h0, d};
    do begin
      @(posedge clock);
      k++;
    end while (av_rsp.waitrequest !== 1'b0 && k < 50);
    rd = av_rsp.readdata[7:0];
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    evt_in[k] <= 1'b1;
    @(posedge clock);
    evt_in[k] <= 1'b0;
  endtask
  // Counts sampled highs of one output: 0 event, 1 blank, 2 capture.
  task automatic cnt(input int span, input int s, output int c);
    c = 0;
    repeat (span) begin
      @(posedge clock);
      if ((s == 0 && zc_event === 1'b1) || (s == 1 && blank_active === 1'b1)
          || (s == 2 && cap === 1'b1))
        c++;
    end
  endtask
  task automatic t_reset;
    rdchk(ADDR_SCR, 8'h00);
    rdchk(ADDR_ZFR, 8'h0f);
    chk(phase_gnd_en, 1'b1);
    bus(1'b1, ADDR_SCR, 8'h8f);
    rdchk(ADDR_SCR, 8'h8f);
    rdchk(5'h10, 8'h00);
  endtask
  // Steady event spacing with the input held high is count plus one times tick.
  task automatic t_filter;
    for (int s = 0; s < 2; s++)
      for (int f = 0; f < 4; f++) begin
        bus(1'b1, ADDR_ZFR, s ? 8'h30 : 8'h00);
        bus(1'b1, ADDR_SCR, {4'h8, f[1:0], 2'b00});
        zc_level <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (zc_event !== 1'b1 && n < 600);
        cnt(1, 0, n);
        n = 1;
        do begin @(posedge clock); n++; end while (zc_event !== 1'b1 && n < 600);
        chk(n, (s ? 4 : 1) * (4 << f));
      end
  endtask
  task automatic t_gate;
    bus(1'b1, ADDR_SCR, 8'h00);
    cnt(300, 0, n);
    chk(n, 0);
    bus(1'b1, ADDR_CTRL, 8'h21);
    zc_level <= 1'b0;
    repeat (4) @(posedge clock);
    pulse(2);
    zc_level <= 1'b1;
    repeat (4) @(posedge clock);
    pulse(2);
    pulse(2);
    pulse(2);
    cnt(3, 0, n);
    chk(n, 0);
    pulse(2);
    cnt(4, 0, n);
    chk(n, 1);
    rdchk(ADDR_STAT, 8'h01);
    bus(1'b1, ADDR_STAT, 8'h01);
    rdchk(ADDR_STAT, 8'h00);
    zc_level <= 1'b0;
    bus(1'b1, ADDR_CTRL, 8'h00);
  endtask
  task automatic t_blank;
    logic [3:0] w [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_ZFR, {4'h0, w[i % 4]});
      if (i == 4) bus(1'b1, ADDR_CTRL, 8'h02);
      pulse(3);
      cnt(900, 1, n);
      chk(n, i == 4 ? 0 : (w[i] < 8 ? (w[i] + 1) * 20 : (w[i] - 5) * 80));
    end
    bus(1'b1, ADDR_CTRL, 8'h00);
  endtask
  task automatic t_capture;
    bus(1'b1, ADDR_CTRL, 8'h40);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, ADDR_SCR, {6'h00, e[0], 1'b0});
      pulse(e ? 1 : 0);
      cnt(4, 2, n);
      chk(n, 0);
      pulse(e ? 0 : 1);
      cnt(4, 2, n);
      chk(n, 1);
    end
  endtask
  task automatic t_float;
    bus(1'b1, ADDR_SCR, 8'h01);
    repeat (2) @(posedge clock);
    chk(phase_gnd_en, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, ctl[i]);
      repeat (2) @(posedge clock);
      chk(phase_gnd_en, 1'b1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_filter;
    t_gate;
    t_blank;
    t_capture;
    t_float;
    results;
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    results;
  end
endmodule
`default_nettype wire
